// >>> hw/lrb_pkg.sv
// Package for the low I/O register bank: addresses, field masks and codes.
// Assumes a single 100 MHz clock domain shared with the processor core.
package lrb_pkg;

    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 8;

    typedef logic [ADDR_W-1:0] lrb_addr_t;
    typedef logic [DATA_W-1:0] lrb_byte_t;

    localparam lrb_addr_t A_POWER_REDUCTION  = 5'h00;
    localparam lrb_addr_t A_ANALOG_DIG_DIS   = 5'h01;
    localparam lrb_addr_t A_RESERVED_02      = 5'h02;
    localparam lrb_addr_t A_CONV_CTRL_B      = 5'h03;
    localparam lrb_addr_t A_CONV_RESULT_LOW  = 5'h04;
    localparam lrb_addr_t A_CONV_RESULT_HIGH = 5'h05;
    localparam lrb_addr_t A_CONV_CTRL_A      = 5'h06;
    localparam lrb_addr_t A_CONV_CHAN_SEL    = 5'h07;
    localparam lrb_addr_t A_COMP_CTRL        = 5'h08;
    localparam lrb_addr_t A_RESERVED_09      = 5'h09;
    localparam lrb_addr_t A_RESERVED_0A      = 5'h0a;
    localparam lrb_addr_t A_T1_FLAGS         = 5'h0b;
    localparam lrb_addr_t A_T1_MASK          = 5'h0c;
    localparam lrb_addr_t A_SER_CTRL         = 5'h0d;
    localparam lrb_addr_t A_SER_STATUS       = 5'h0e;
    localparam lrb_addr_t A_SER_SHIFT        = 5'h0f;
    localparam lrb_addr_t A_SER_BUFFER       = 5'h10;
    localparam lrb_addr_t A_RESERVED_11      = 5'h11;
    localparam lrb_addr_t A_PIN_CHG_MASK     = 5'h12;
    localparam lrb_addr_t A_SCRATCH_0        = 5'h13;
    localparam lrb_addr_t A_SCRATCH_1        = 5'h14;
    localparam lrb_addr_t A_SCRATCH_2        = 5'h15;
    localparam lrb_addr_t A_PORTB_PINS       = 5'h16;
    localparam lrb_addr_t A_PORTB_DIR        = 5'h17;

    // Implemented bits of the masked registers; writable registers without an entry keep all eight bits.
    localparam lrb_byte_t M_POWER_REDUCTION = 8'h0f;
    localparam lrb_byte_t M_CONV_CTRL_B     = 8'hd7;
    localparam lrb_byte_t M_CONV_CTRL_A_RW  = 8'hef;
    localparam lrb_byte_t M_CONV_CTRL_A_W1C = 8'h10;
    localparam lrb_byte_t M_COMP_CTRL_RW    = 8'hcf;
    localparam lrb_byte_t M_COMP_CTRL_W1C   = 8'h10;
    localparam lrb_byte_t M_COMP_CTRL_OUT   = 8'h20;
    localparam lrb_byte_t M_T1_FLAGS        = 8'h27;
    localparam lrb_byte_t M_T1_MASK         = 8'h27;
    localparam lrb_byte_t M_SER_STATUS_W1C  = 8'he0;
    localparam lrb_byte_t M_SER_STATUS_RW   = 8'h0f;
    localparam lrb_byte_t M_SER_STATUS_RO   = 8'h10;
    localparam lrb_byte_t M_PORTB           = 8'h0f;
    localparam lrb_byte_t ZERO_BYTE         = 8'h00;

    // Operation codes issued by the core.
    typedef enum logic [5:0] {
        OP_IDLE       = 6'h01,
        OP_READ       = 6'h02,
        OP_WRITE      = 6'h04,
        OP_SET_BIT    = 6'h08,
        OP_CLEAR_BIT  = 6'h10,
        OP_TEST_BIT   = 6'h20
    } lrb_op_e;

endpackage

// >>> hw/lrb_access_if.sv
// Interface carrying one decoded register access from the decoder to the bank.
// Assumes both ends share clk.
interface lrb_access_if;
    logic                    wr_en;
    lrb_pkg::lrb_addr_t      addr;
    lrb_pkg::lrb_byte_t      wr_data;
    lrb_pkg::lrb_byte_t      one_mask;
    logic                    w1c_enable;

    modport decoder (output wr_en, output addr, output wr_data, output one_mask,
                     output w1c_enable);
    modport bank    (input wr_en, input addr, input wr_data, input one_mask,
                     input w1c_enable);
endinterface

// >>> hw/lrb_op_decode.sv
// Turns a core operation into a byte write with a per-bit clear-by-one mask.
// Assumes the core presents op, address, bit number and data for one cycle.
module lrb_op_decode (
    input  wire logic             op_valid,
    input  lrb_pkg::lrb_op_e      op,
    input  lrb_pkg::lrb_addr_t    addr,
    input  wire logic [2:0]       bit_sel,
    input  lrb_pkg::lrb_byte_t    wr_data,
    input  lrb_pkg::lrb_byte_t    cur_value,
    lrb_access_if.decoder         acc
);
    lrb_pkg::lrb_byte_t bit_onehot;

    always_comb begin
        bit_onehot     = lrb_pkg::lrb_byte_t'(1) << bit_sel;
        acc.addr       = addr;
        acc.wr_en      = 1'b0;
        acc.wr_data    = lrb_pkg::ZERO_BYTE;
        acc.one_mask   = lrb_pkg::ZERO_BYTE;
        acc.w1c_enable = 1'b0;
        if (op_valid) begin
            case (op)
                lrb_pkg::OP_WRITE: begin
                    acc.wr_en      = 1'b1;
                    acc.wr_data    = wr_data;
                    acc.one_mask   = wr_data;
                    acc.w1c_enable = 1'b1;
                end
                // Only the addressed bit is merged; flags elsewhere see no one.
                lrb_pkg::OP_SET_BIT: begin
                    acc.wr_en      = 1'b1;
                    acc.wr_data    = cur_value | bit_onehot;
                    acc.one_mask   = bit_onehot;
                    acc.w1c_enable = 1'b1;
                end
                lrb_pkg::OP_CLEAR_BIT: begin
                    acc.wr_en      = 1'b1;
                    acc.wr_data    = cur_value & ~bit_onehot;
                    acc.one_mask   = lrb_pkg::ZERO_BYTE;
                    acc.w1c_enable = 1'b0;
                end
                default: begin
                    acc.wr_en = 1'b0;
                end
            endcase
        end
    end
endmodule

// >>> hw/lrb_top.sv
// Low I/O register bank: read, write, bit set, bit clear and bit test.
// Assumes the core drives one operation per cycle in the clk domain and
// that peripheral status inputs are synchronous to clk except port pins.
module lrb_top (
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic               op_valid,
    input  lrb_pkg::lrb_op_e        op,
    input  wire logic [5:0]         io_addr,
    input  wire logic [2:0]         bit_sel,
    input  lrb_pkg::lrb_byte_t      wr_data,
    output lrb_pkg::lrb_byte_t      rd_data,
    output logic                    skip_next,
    input  wire logic [3:0]         portb_pins,
    input  lrb_pkg::lrb_byte_t      conv_result_low,
    input  lrb_pkg::lrb_byte_t      conv_result_high,
    input  lrb_pkg::lrb_byte_t      ser_buffer,
    input  wire logic               conv_done_evt,
    input  wire logic               comp_evt,
    input  wire logic               comp_out,
    input  lrb_pkg::lrb_byte_t      t1_flag_evt,
    input  wire logic [2:0]         ser_flag_evt,
    input  wire logic               ser_busy,
    output lrb_pkg::lrb_byte_t      power_reduction,
    output lrb_pkg::lrb_byte_t      analog_input_digital_disable,
    output lrb_pkg::lrb_byte_t      converter_control_a,
    output lrb_pkg::lrb_byte_t      converter_control_b,
    output lrb_pkg::lrb_byte_t      converter_channel_select,
    output lrb_pkg::lrb_byte_t      comparator_control,
    output lrb_pkg::lrb_byte_t      timer1_interrupt_flags,
    output lrb_pkg::lrb_byte_t      timer1_interrupt_mask,
    output lrb_pkg::lrb_byte_t      serial_iface_control,
    output lrb_pkg::lrb_byte_t      serial_iface_status,
    output lrb_pkg::lrb_byte_t      serial_iface_shift_data,
    output lrb_pkg::lrb_byte_t      pin_change_mask_low,
    output lrb_pkg::lrb_byte_t      portb_direction
);

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        lrb_pkg::lrb_byte_t power_reduction;
        lrb_pkg::lrb_byte_t analog_dis;
        lrb_pkg::lrb_byte_t conv_ctrl_b;
        lrb_pkg::lrb_byte_t conv_ctrl_a;
        lrb_pkg::lrb_byte_t conv_chan;
        lrb_pkg::lrb_byte_t comp_ctrl;
        lrb_pkg::lrb_byte_t t1_flags;
        lrb_pkg::lrb_byte_t t1_mask;
        lrb_pkg::lrb_byte_t ser_ctrl;
        lrb_pkg::lrb_byte_t ser_status;
        lrb_pkg::lrb_byte_t ser_shift;
        lrb_pkg::lrb_byte_t pin_mask;
        lrb_pkg::lrb_byte_t scratch0;
        lrb_pkg::lrb_byte_t scratch1;
        lrb_pkg::lrb_byte_t scratch2;
        lrb_pkg::lrb_byte_t portb_dir;
        logic [3:0]         pins_meta;
        logic [3:0]         pins_sync;
        lrb_pkg::lrb_byte_t rd_data;
        logic               skip;
    } lrb_state_s;

    lrb_state_s         st_reg;
    lrb_state_s         st_next;
    lrb_pkg::lrb_byte_t cur_value;
    lrb_pkg::lrb_addr_t low_addr;
    logic               in_range;
    logic               dec_valid;

    lrb_access_if acc ();

    ////////////////////////////////////////////////////////////////////////////

    // Reads assemble implemented bits only; reserved bits and holes are zero.
    function automatic lrb_pkg::lrb_byte_t read_reg(input lrb_state_s s,
                                                    input lrb_pkg::lrb_addr_t a,
                                                    input lrb_pkg::lrb_byte_t lo,
                                                    input lrb_pkg::lrb_byte_t hi,
                                                    input lrb_pkg::lrb_byte_t sb,
                                                    input logic co,
                                                    input logic bsy);
        lrb_pkg::lrb_byte_t v;
        v = lrb_pkg::ZERO_BYTE;
        if (a == lrb_pkg::A_POWER_REDUCTION) begin
            v = s.power_reduction;
        end else if (a == lrb_pkg::A_ANALOG_DIG_DIS) begin
            v = s.analog_dis;
        end else if (a == lrb_pkg::A_CONV_CTRL_B) begin
            v = s.conv_ctrl_b;
        end else if (a == lrb_pkg::A_CONV_RESULT_LOW) begin
            v = lo;
        end else if (a == lrb_pkg::A_CONV_RESULT_HIGH) begin
            v = hi;
        end else if (a == lrb_pkg::A_CONV_CTRL_A) begin
            v = s.conv_ctrl_a;
        end else if (a == lrb_pkg::A_CONV_CHAN_SEL) begin
            v = s.conv_chan;
        end else if (a == lrb_pkg::A_COMP_CTRL) begin
            v = (s.comp_ctrl & ~lrb_pkg::M_COMP_CTRL_OUT)
                | (co ? lrb_pkg::M_COMP_CTRL_OUT : lrb_pkg::ZERO_BYTE);
        end else if (a == lrb_pkg::A_T1_FLAGS) begin
            v = s.t1_flags;
        end else if (a == lrb_pkg::A_T1_MASK) begin
            v = s.t1_mask;
        end else if (a == lrb_pkg::A_SER_CTRL) begin
            v = s.ser_ctrl;
        end else if (a == lrb_pkg::A_SER_STATUS) begin
            v = (s.ser_status & ~lrb_pkg::M_SER_STATUS_RO)
                | (bsy ? lrb_pkg::M_SER_STATUS_RO : lrb_pkg::ZERO_BYTE);
        end else if (a == lrb_pkg::A_SER_SHIFT) begin
            v = s.ser_shift;
        end else if (a == lrb_pkg::A_SER_BUFFER) begin
            v = sb;
        end else if (a == lrb_pkg::A_PIN_CHG_MASK) begin
            v = s.pin_mask;
        end else if (a == lrb_pkg::A_SCRATCH_0) begin
            v = s.scratch0;
        end else if (a == lrb_pkg::A_SCRATCH_1) begin
            v = s.scratch1;
        end else if (a == lrb_pkg::A_SCRATCH_2) begin
            v = s.scratch2;
        end else if (a == lrb_pkg::A_PORTB_PINS) begin
            v = {4'h0, s.pins_sync};
        end else if (a == lrb_pkg::A_PORTB_DIR) begin
            v = s.portb_dir;
        end
        return v;
    endfunction

    // Flag update: hardware set wins over a clear by one in the same cycle.
    function automatic lrb_pkg::lrb_byte_t w1c(input lrb_pkg::lrb_byte_t cur,
                                               input lrb_pkg::lrb_byte_t ones,
                                               input lrb_pkg::lrb_byte_t fmask,
                                               input lrb_pkg::lrb_byte_t evt);
        return ((cur & ~(ones & fmask)) | evt) & fmask;
    endfunction

    // Ordinary field update limited to implemented bits.
    function automatic lrb_pkg::lrb_byte_t rw(input lrb_pkg::lrb_byte_t cur,
                                              input lrb_pkg::lrb_byte_t d,
                                              input lrb_pkg::lrb_byte_t fmask);
        return (cur & ~fmask) | (d & fmask);
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    assign in_range  = (io_addr[5] == 1'b0);
    assign low_addr  = io_addr[4:0];
    assign dec_valid = op_valid & in_range;
    assign cur_value = read_reg(st_reg, low_addr, conv_result_low, conv_result_high,
                                ser_buffer, comp_out, ser_busy);

    lrb_op_decode u_decode (
        .op_valid  (dec_valid),
        .op        (op),
        .addr      (low_addr),
        .bit_sel   (bit_sel),
        .wr_data   (wr_data),
        .cur_value (cur_value),
        .acc       (acc)
    );

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        lrb_pkg::lrb_byte_t ones;
        lrb_pkg::lrb_byte_t d;
        st_next = st_reg;
        ones    = acc.w1c_enable ? acc.one_mask : lrb_pkg::ZERO_BYTE;
        d       = acc.wr_data;
        st_next.pins_meta = portb_pins;
        st_next.pins_sync = st_reg.pins_meta;
        st_next.skip      = 1'b0;

        // Peripheral events always land; writes below merge with them.
        st_next.conv_ctrl_a = w1c(st_reg.conv_ctrl_a, ZERO(), lrb_pkg::M_CONV_CTRL_A_W1C,
                                  conv_done_evt ? lrb_pkg::M_CONV_CTRL_A_W1C : ZERO())
                              | (st_reg.conv_ctrl_a & lrb_pkg::M_CONV_CTRL_A_RW);
        st_next.comp_ctrl   = w1c(st_reg.comp_ctrl, ZERO(), lrb_pkg::M_COMP_CTRL_W1C,
                                  comp_evt ? lrb_pkg::M_COMP_CTRL_W1C : ZERO())
                              | (st_reg.comp_ctrl & lrb_pkg::M_COMP_CTRL_RW);
        st_next.t1_flags    = w1c(st_reg.t1_flags, ZERO(), lrb_pkg::M_T1_FLAGS, t1_flag_evt);
        st_next.ser_status  = w1c(st_reg.ser_status, ZERO(), lrb_pkg::M_SER_STATUS_W1C,
                                  {ser_flag_evt, 5'h00})
                              | (st_reg.ser_status & lrb_pkg::M_SER_STATUS_RW);

        if (acc.wr_en) begin
            if (acc.addr == lrb_pkg::A_POWER_REDUCTION) begin
                st_next.power_reduction = d & lrb_pkg::M_POWER_REDUCTION;
            end else if (acc.addr == lrb_pkg::A_ANALOG_DIG_DIS) begin
                st_next.analog_dis = d;
            end else if (acc.addr == lrb_pkg::A_CONV_CTRL_B) begin
                st_next.conv_ctrl_b = d & lrb_pkg::M_CONV_CTRL_B;
            end else if (acc.addr == lrb_pkg::A_CONV_CTRL_A) begin
                st_next.conv_ctrl_a = rw(w1c(st_reg.conv_ctrl_a, ones,
                                        lrb_pkg::M_CONV_CTRL_A_W1C,
                                        conv_done_evt ? lrb_pkg::M_CONV_CTRL_A_W1C : ZERO()),
                                        d, lrb_pkg::M_CONV_CTRL_A_RW);
            end else if (acc.addr == lrb_pkg::A_CONV_CHAN_SEL) begin
                st_next.conv_chan = d;
            end else if (acc.addr == lrb_pkg::A_COMP_CTRL) begin
                st_next.comp_ctrl = rw(w1c(st_reg.comp_ctrl, ones,
                                      lrb_pkg::M_COMP_CTRL_W1C,
                                      comp_evt ? lrb_pkg::M_COMP_CTRL_W1C : ZERO()),
                                      d, lrb_pkg::M_COMP_CTRL_RW);
            end else if (acc.addr == lrb_pkg::A_T1_FLAGS) begin
                st_next.t1_flags = w1c(st_reg.t1_flags, ones, lrb_pkg::M_T1_FLAGS,
                                       t1_flag_evt);
            end else if (acc.addr == lrb_pkg::A_T1_MASK) begin
                st_next.t1_mask = d & lrb_pkg::M_T1_MASK;
            end else if (acc.addr == lrb_pkg::A_SER_CTRL) begin
                st_next.ser_ctrl = d;
            end else if (acc.addr == lrb_pkg::A_SER_STATUS) begin
                st_next.ser_status = rw(w1c(st_reg.ser_status, ones,
                                       lrb_pkg::M_SER_STATUS_W1C, {ser_flag_evt, 5'h00}),
                                       d, lrb_pkg::M_SER_STATUS_RW);
            end else if (acc.addr == lrb_pkg::A_SER_SHIFT) begin
                st_next.ser_shift = d;
            end else if (acc.addr == lrb_pkg::A_PIN_CHG_MASK) begin
                st_next.pin_mask = d;
            end else if (acc.addr == lrb_pkg::A_SCRATCH_0) begin
                st_next.scratch0 = d;
            end else if (acc.addr == lrb_pkg::A_SCRATCH_1) begin
                st_next.scratch1 = d;
            end else if (acc.addr == lrb_pkg::A_SCRATCH_2) begin
                st_next.scratch2 = d;
            end else if (acc.addr == lrb_pkg::A_PORTB_DIR) begin
                st_next.portb_dir = d & lrb_pkg::M_PORTB;
            end
            // Reserved and read-only addresses fall through untouched.
        end

        if (op_valid && op == lrb_pkg::OP_READ) begin
            st_next.rd_data = in_range ? cur_value : lrb_pkg::ZERO_BYTE;
        end
        if (dec_valid && op == lrb_pkg::OP_TEST_BIT) begin
            // Skip when the selected bit equals the polarity in wr_data bit 0.
            st_next.skip = (cur_value[bit_sel] == wr_data[0]);
        end

        if (srst) begin
            st_next = '0;
        end
    end

    function automatic lrb_pkg::lrb_byte_t ZERO();
        return lrb_pkg::ZERO_BYTE;
    endfunction

    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    ////////////////////////////////////////////////////////////////////////////

    assign rd_data                      = st_reg.rd_data;
    assign skip_next                    = st_reg.skip;
    assign power_reduction              = st_reg.power_reduction;
    assign analog_input_digital_disable = st_reg.analog_dis;
    assign converter_control_a          = st_reg.conv_ctrl_a;
    assign converter_control_b          = st_reg.conv_ctrl_b;
    assign converter_channel_select     = st_reg.conv_chan;
    assign comparator_control           = st_reg.comp_ctrl;
    assign timer1_interrupt_flags       = st_reg.t1_flags;
    assign timer1_interrupt_mask        = st_reg.t1_mask;
    assign serial_iface_control         = st_reg.ser_ctrl;
    assign serial_iface_status          = st_reg.ser_status;
    assign serial_iface_shift_data      = st_reg.ser_shift;
    assign pin_change_mask_low          = st_reg.pin_mask;
    assign portb_direction              = st_reg.portb_dir;

endmodule

// >>> testbench/lrb_top_sva.sv
// Checker for the low register bank, watching only the top module ports.
// Assumes it is bound to lrb_top and that everything runs on clk.
module lrb_top_sva (
    input wire logic          clk,
    input wire logic          srst,
    input wire logic          op_valid,
    input lrb_pkg::lrb_op_e   op,
    input wire logic [5:0]    io_addr,
    input wire logic [2:0]    bit_sel,
    input lrb_pkg::lrb_byte_t wr_data,
    input lrb_pkg::lrb_byte_t rd_data,
    input wire logic          skip_next,
    input lrb_pkg::lrb_byte_t t1_flag_evt,
    input lrb_pkg::lrb_byte_t power_reduction,
    input lrb_pkg::lrb_byte_t timer1_interrupt_flags,
    input lrb_pkg::lrb_byte_t portb_direction
);
    wire logic       lo   = io_addr < 6'h20;
    wire logic [7:0] sel  = 8'h01 << bit_sel;
    wire logic       rsvd = !lo || io_addr inside {6'h02, 6'h09, 6'h0a, 6'h11};
    wire logic       bop  = op_valid && op inside {lrb_pkg::OP_SET_BIT, lrb_pkg::OP_CLEAR_BIT};
    wire logic       quiet = op_valid && t1_flag_evt == 8'h00 && io_addr == 6'h0b;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////////
    property p_skip_src;
        skip_next |-> $past(op_valid && op == lrb_pkg::OP_TEST_BIT && lo);
    endproperty
    a_skip_src: assert property (p_skip_src) else $error("skip without a bit test");
    property p_skip_val;
        op_valid && op == lrb_pkg::OP_TEST_BIT && io_addr == 6'h17
        |=> skip_next == ($past(portb_direction[bit_sel]) == $past(wr_data[0]));
    endproperty
    a_skip_val: assert property (p_skip_val) else $error("wrong skip result");
    property p_set;
        op_valid && op == lrb_pkg::OP_SET_BIT && io_addr == 6'h17
        |=> portb_direction == (($past(portb_direction) | $past(sel)) & 8'h0f);
    endproperty
    a_set: assert property (p_set) else $error("bit set went wrong");
    property p_clr;
        op_valid && op == lrb_pkg::OP_CLEAR_BIT && io_addr == 6'h17
        |=> portb_direction == ($past(portb_direction) & ~$past(sel));
    endproperty
    a_clr: assert property (p_clr) else $error("bit clear went wrong");
    property p_hi;
        bop && !lo |=> $stable(portb_direction) && $stable(power_reduction);
    endproperty
    a_hi: assert property (p_hi) else $error("high bit op changed a register");
    property p_w1s;
        quiet && op == lrb_pkg::OP_SET_BIT
        |=> timer1_interrupt_flags == ($past(timer1_interrupt_flags) & ~$past(sel));
    endproperty
    a_w1s: assert property (p_w1s) else $error("flag bit op went wrong");
    property p_w1c;
        quiet && op == lrb_pkg::OP_WRITE
        |=> timer1_interrupt_flags == ($past(timer1_interrupt_flags) & ~$past(wr_data));
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag write went wrong");
    property p_clrf;
        quiet && op == lrb_pkg::OP_CLEAR_BIT |=> $stable(timer1_interrupt_flags);
    endproperty
    a_clrf: assert property (p_clrf) else $error("bit clear disturbed flags");
    property p_rsvd_rd;
        op_valid && op == lrb_pkg::OP_READ && rsvd |=> rd_data == 8'h00;
    endproperty
    a_rsvd_rd: assert property (p_rsvd_rd) else $error("reserved read not zero");
    property p_rsvd_wr;
        op_valid && op == lrb_pkg::OP_WRITE && rsvd
        |=> $stable(portb_direction) && $stable(power_reduction);
    endproperty
    a_rsvd_wr: assert property (p_rsvd_wr) else $error("reserved write had effect");
endmodule

// >>> testbench/lrb_core_model.sv
// Processor core model issuing one I/O operation per call.
// Assumes only the bench calls issue and nothing else drives these lines.
module lrb_core_model (
    input wire logic          clk,
    output logic              op_valid,
    output lrb_pkg::lrb_op_e  op,
    output logic [5:0]        io_addr,
    output logic [2:0]        bit_sel,
    output lrb_pkg::lrb_byte_t wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Raised only by scenarios that probe how reserved places react.
    logic misuse = 1'b0;
    initial begin
        op_valid = 1'b0;
        op = lrb_pkg::OP_IDLE;
        io_addr = 6'h00;
        bit_sel = 3'h0;
        wr_data = 8'h00;
    end
    task automatic issue(input lrb_pkg::lrb_op_e o, input logic [5:0] a,
                         input logic [2:0] b, input lrb_pkg::lrb_byte_t d);
        logic go;
        go = misuse || !(o == lrb_pkg::OP_WRITE && a inside {6'h02, 6'h09, 6'h0a, 6'h11});
        if (!misuse && a == 6'h17) begin
            d = d & lrb_pkg::M_PORTB;
        end
        @(posedge clk);
        op_valid <= go;
        op <= o;
        io_addr <= a;
        bit_sel <= b;
        wr_data <= d;
        @(posedge clk);
        // Released lines flip so a stale value never looks like a new request.
        op_valid <= 1'b0;
        op <= lrb_pkg::OP_IDLE;
        io_addr <= ~a;
        bit_sel <= ~b;
        wr_data <= ~d;
    endtask
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the low register bank with a core model.
// Assumes lrb_pkg, the design files and the checker are compiled first.
`define LRB_CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, srst = 1'b1, comp_o = 1'b0, ser_b = 1'b0, cdone = 1'b0, cevt = 1'b0;
    logic [3:0] pins = 4'h0;
    logic [2:0] sevt = 3'h0, b;
    lrb_pkg::lrb_byte_t c_lo = 8'h00, c_hi = 8'h00, sbuf = 8'h00, t1evt = 8'h00, d, v;
    lrb_pkg::lrb_byte_t rd_data, wr_data, wv [32], ro [24];
    lrb_pkg::lrb_op_e op;
    logic op_valid, skip_next, pol;
    logic [5:0] io_addr, a6;
    logic [2:0] bit_sel;
    int error_cnt = 0, cmp_count = 0;
    lrb_core_model core (.clk(clk), .op_valid(op_valid), .op(op), .io_addr(io_addr),
                         .bit_sel(bit_sel), .wr_data(wr_data));
    lrb_top uut (.clk(clk), .srst(srst), .op_valid(op_valid), .op(op), .io_addr(io_addr),
        .bit_sel(bit_sel), .wr_data(wr_data), .rd_data(rd_data), .skip_next(skip_next),
        .portb_pins(pins), .conv_result_low(c_lo), .conv_result_high(c_hi), .ser_buffer(sbuf),
        .conv_done_evt(cdone), .comp_evt(cevt), .comp_out(comp_o), .t1_flag_evt(t1evt),
        .ser_flag_evt(sevt), .ser_busy(ser_b), .power_reduction(ro[0]),
        .analog_input_digital_disable(ro[1]), .converter_control_b(ro[3]),
        .converter_control_a(ro[6]), .converter_channel_select(ro[7]), .comparator_control(ro[8]),
        .timer1_interrupt_flags(ro[11]), .timer1_interrupt_mask(ro[12]),
        .serial_iface_control(ro[13]), .serial_iface_status(ro[14]), .pin_change_mask_low(ro[18]),
        .serial_iface_shift_data(ro[15]), .portb_direction(ro[23]));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic lrb_pkg::lrb_byte_t exp_rd(input logic [5:0] a, input lrb_pkg::lrb_byte_t x);
        if (a > 6'h17 || a inside {6'h02, 6'h09, 6'h0a, 6'h0b, 6'h11}) return 8'h00;
        case (a[4:0])
            5'h00: return x & lrb_pkg::M_POWER_REDUCTION;
            5'h03: return x & lrb_pkg::M_CONV_CTRL_B;
            5'h04: return c_lo;
            5'h05: return c_hi;
            5'h06: return x & lrb_pkg::M_CONV_CTRL_A_RW;
            5'h08: return (x & lrb_pkg::M_COMP_CTRL_RW) | {2'h0, comp_o, 5'h00};
            5'h0c: return x & lrb_pkg::M_T1_MASK;
            5'h0e: return (x & lrb_pkg::M_SER_STATUS_RW) | {3'h0, ser_b, 4'h0};
            5'h10: return sbuf;
            5'h16: return {4'h0, pins};
            5'h17: return x & lrb_pkg::M_PORTB;
            default: return x;
        endcase
    endfunction
    task automatic rd(input logic [5:0] a);
        core.issue(lrb_pkg::OP_READ, a, 3'h0, 8'h00);
        #1;
    endtask
    task automatic chk_flag(input logic [5:0] a, input logic [2:0] fb, input lrb_pkg::lrb_byte_t f);
        rd(a);
        `LRB_CHECK(rd_data, exp_rd(a, wv[a]) | f)
        core.issue(lrb_pkg::OP_SET_BIT, a, fb, 8'h00);
        rd(a);
        `LRB_CHECK(rd_data, exp_rd(a, wv[a]) | (f & ~(8'h01 << fb)))
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 clk = ~clk;
    end
    // The whole sequence needs well under 2000 cycles.
    initial begin
        #100us;
        error_cnt++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'h961e72fe));
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        {pins, c_lo, c_hi, sbuf, comp_o, ser_b} <= 30'($urandom);
        core.misuse = 1'b1;
        for (int a = 0; a < 64; a++) begin
            d = 8'($urandom);
            rd(6'(a));
            `LRB_CHECK(rd_data, exp_rd(6'(a), 8'h00))
            core.issue(lrb_pkg::OP_WRITE, 6'(a), 3'h0, d);
            if (a < 32) wv[a] = d;
            rd(6'(a));
            `LRB_CHECK(rd_data, exp_rd(6'(a), d))
            if (a inside {0, 1, 3, 6, 7, 8, 11, 12, 13, 14, 15, 18, 23})
                `LRB_CHECK(ro[a], exp_rd(6'(a), d) & ~{2'h0, a == 8, a == 14, 4'h0})
        end
        core.misuse = 1'b0;
        for (int i = 0; i < 24; i++) begin
            a6 = (i % 2 == 1) ? 6'h17 : 6'h13 + 6'(i % 3);
            b = 3'($urandom);
            pol = 1'($urandom);
            core.issue(pol ? lrb_pkg::OP_SET_BIT : lrb_pkg::OP_CLEAR_BIT, a6, b, 8'h00);
            wv[a6] = pol ? wv[a6] | (8'h01 << b) : wv[a6] & ~(8'h01 << b);
            core.issue(lrb_pkg::OP_SET_BIT, a6 + 6'h20, ~b, 8'h00);
            rd(a6);
            `LRB_CHECK(rd_data, exp_rd(a6, wv[a6]))
            a6 = (i % 3 == 0) ? 6'h13 : 6'h15 + 6'(i % 3);
            core.issue(lrb_pkg::OP_TEST_BIT, a6, b, {7'h00, pol});
            #1;
            v = exp_rd(a6, wv[a6]);
            `LRB_CHECK(skip_next, v[b] == pol)
        end
        @(posedge clk);
        {cdone, cevt, t1evt, sevt} <= {2'h3, 8'hff, 3'h7};
        @(posedge clk);
        {cdone, cevt, t1evt, sevt} <= '0;
        chk_flag(6'h06, 3'h4, 8'h10);
        chk_flag(6'h08, 3'h4, 8'h10);
        chk_flag(6'h0e, 3'h6, 8'he0);
        chk_flag(6'h0b, 3'h0, 8'h27);
        core.issue(lrb_pkg::OP_CLEAR_BIT, 6'h0b, 3'h5, 8'h00);
        core.issue(lrb_pkg::OP_WRITE, 6'h0b, 3'h0, 8'h04);
        rd(6'h0b);
        `LRB_CHECK(rd_data, 8'h22)
        give_verdict();
    end
endmodule
bind lrb_top lrb_top_sva chk (.clk(clk), .srst(srst), .op_valid(op_valid), .op(op),
    .io_addr(io_addr), .bit_sel(bit_sel), .wr_data(wr_data), .rd_data(rd_data),
    .skip_next(skip_next), .t1_flag_evt(t1_flag_evt), .power_reduction(power_reduction),
    .timer1_interrupt_flags(timer1_interrupt_flags), .portb_direction(portb_direction));
